// [shared/clkgen_csr_pkg.sv]
// package: register map, field layout and carrier types of the clock generator status and control bank
package clkgen_csr_pkg;

    // ============================================================
    // register offsets
    typedef logic [15:0] reg_addr_t;

    localparam reg_addr_t ADDR_LIVE_ALARM    = 16'h000c;
    localparam reg_addr_t ADDR_LIVE_INLOSS   = 16'h000d;
    localparam reg_addr_t ADDR_ALARM_STICKY  = 16'h0011;
    localparam reg_addr_t ADDR_INLOSS_STICKY = 16'h0012;
    localparam reg_addr_t ADDR_ALARM_MASK    = 16'h0017;
    localparam reg_addr_t ADDR_INLOSS_MASK   = 16'h0018;
    localparam reg_addr_t ADDR_SOFT_RESET    = 16'h001c;
    localparam reg_addr_t ADDR_FREQ_STEP     = 16'h001d;
    localparam reg_addr_t ADDR_POWER_CTRL    = 16'h001e;
    localparam reg_addr_t ADDR_REF_SELECT    = 16'h0021;
    localparam reg_addr_t ADDR_WIRE_MODE     = 16'h002b;

    // ============================================================
    // field positions
    localparam int BIT_CALIBRATING  = 0;
    localparam int BIT_CRYSTAL_LOSS = 1;
    localparam int BIT_REF_LOSS     = 2;
    localparam int BIT_LOCK_LOSS    = 3;
    localparam int BIT_BUS_TIMEOUT  = 5;
    localparam int BIT_SOFT_RESET   = 0;
    localparam int BIT_STEP_UP      = 0;
    localparam int BIT_STEP_DOWN    = 1;
    localparam int BIT_LOW_POWER    = 0;
    localparam int BIT_HARD_RESET   = 1;
    localparam int BIT_ALIGN        = 2;
    localparam int BIT_SEL_SOURCE   = 0;
    localparam int SEL_FIELD_LSB    = 1;
    localparam int BIT_SHARED_LINE  = 3;

    localparam logic [7:0] ALARM_VALID  = 8'h2f;
    localparam logic [7:0] INLOSS_VALID = 8'h0f;

    // ============================================================
    // values after reset
    localparam logic [7:0] RST_STICKY      = 8'h00;
    localparam logic [7:0] RST_ALARM_MASK  = 8'h00;
    localparam logic [7:0] RST_INLOSS_MASK = 8'h00;
    localparam logic [7:0] RST_REF_SELECT  = 8'h00;
    localparam logic [7:0] RST_WIRE_MODE   = 8'h00;
    localparam logic [1:0] RST_PIN_SELECT  = 2'h0;

    // ============================================================
    // carriers
    typedef struct packed {
        logic bus_timeout;
        logic lock_loss_status;
        logic reference_signal_loss;
        logic crystal_signal_loss;
        logic calibrating_status;
    } alarm_live_t;

    typedef struct packed {
        logic       en;
        reg_addr_t  addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic       soft_reset_pulse;
        logic       freq_step_up;
        logic       freq_step_down;
        logic       align_pulse;
        logic       low_power_request;
        logic       hard_reset;
        logic       shared_data_line_mode;
        logic [1:0] reference_select;
    } core_ctrl_t;

endpackage

// [design/status_flag_and_control_regs.sv]
// module: sticky alarm flags, interrupt masks and control register bank of the clock generator
//
// Contract
// - sticky alarm bit sets on its live source, clears only when software writes 0
// - sticky alarm positions: calibrating 0, crystal 1, reference 2, lock 3, timeout 5
// - four per-input sticky loss flags, each set by live loss, cleared by writing 0
// - alarm mask bit at same position; mask 1 keeps that flag off the interrupt
// - four input loss mask bits; mask 1 keeps that input flag off the interrupt
// - writing 1 to soft reset resets core without reload; bit self-clears, 0 ignored
// - soft reset also realigns the output clocks
// - writing 1 to step-up bit issues one frequency increment; 0 does nothing
// - writing 1 to step-down bit 1 issues one frequency decrement; 0 does nothing
// - low power request holds while its bit is 1
// - hard reset bit resets core as at power up, serial access stays alive
// - writing 1 to self-clearing align bit puts all output dividers in one state
// - select source bit: 0 uses selection pins, 1 uses register field
// - register field picks input zero, one, two, or 3 for crystal input
// - wire mode bit: 0 four-wire, 1 three-wire with shared data line
// - live alarm register reports calibrating, crystal, reference, lock, timeout bits
// - live input loss register follows current condition, not latched
module status_flag_and_control_regs
    import clkgen_csr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire reg_wr_t     wr,
    input  wire logic        rd_en,
    input  wire reg_addr_t   rd_addr,
    input  wire alarm_live_t alarm_live,
    input  wire logic [3:0]  input_loss_live,
    input  wire logic [1:0]  ref_select_pins,
    output      logic [7:0]  rd_data_q,
    output      logic        rd_valid_q,
    output      logic        irq_q,
    output      core_ctrl_t  ctrl_q
);

    // ============================================================
    // live status mapping
    logic [7:0] alarm_live_vec;
    logic [7:0] inloss_live_vec;

    always_comb begin
        alarm_live_vec                   = 8'h00;
        alarm_live_vec[BIT_CALIBRATING]  = alarm_live.calibrating_status;
        alarm_live_vec[BIT_CRYSTAL_LOSS] = alarm_live.crystal_signal_loss;
        alarm_live_vec[BIT_REF_LOSS]     = alarm_live.reference_signal_loss;
        alarm_live_vec[BIT_LOCK_LOSS]    = alarm_live.lock_loss_status;
        alarm_live_vec[BIT_BUS_TIMEOUT]  = alarm_live.bus_timeout;
        inloss_live_vec                  = {4'h0, input_loss_live};
    end

    // ============================================================
    // write decode
    logic wr_alarm_sticky;
    logic wr_inloss_sticky;
    logic wr_alarm_mask;
    logic wr_inloss_mask;
    logic wr_soft_reset;
    logic wr_freq_step;
    logic wr_power;
    logic wr_ref_select;
    logic wr_wire_mode;

    always_comb begin
        wr_alarm_sticky  = wr.en && (wr.addr == ADDR_ALARM_STICKY);
        wr_inloss_sticky = wr.en && (wr.addr == ADDR_INLOSS_STICKY);
        wr_alarm_mask    = wr.en && (wr.addr == ADDR_ALARM_MASK);
        wr_inloss_mask   = wr.en && (wr.addr == ADDR_INLOSS_MASK);
        wr_soft_reset    = wr.en && (wr.addr == ADDR_SOFT_RESET);
        wr_freq_step     = wr.en && (wr.addr == ADDR_FREQ_STEP);
        wr_power         = wr.en && (wr.addr == ADDR_POWER_CTRL);
        wr_ref_select    = wr.en && (wr.addr == ADDR_REF_SELECT);
        wr_wire_mode     = wr.en && (wr.addr == ADDR_WIRE_MODE);
    end

    // ============================================================
    // sticky flags
    logic [7:0] alarm_sticky_q;
    logic [7:0] alarm_sticky_d;
    logic [7:0] inloss_sticky_q;
    logic [7:0] inloss_sticky_d;

    // set beats clear: a live source in the clearing cycle keeps its flag
    for (genvar i = 0; i < 8; i++) begin : g_sticky
        assign alarm_sticky_d[i] = ALARM_VALID[i] & (alarm_live_vec[i]
                                   | (alarm_sticky_q[i] & ~(wr_alarm_sticky & ~wr.data[i])));
        assign inloss_sticky_d[i] = INLOSS_VALID[i] & (inloss_live_vec[i]
                                    | (inloss_sticky_q[i] & ~(wr_inloss_sticky & ~wr.data[i])));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_sticky_q  <= RST_STICKY;
            inloss_sticky_q <= RST_STICKY;
        end else if (ce) begin
            alarm_sticky_q  <= alarm_sticky_d;
            inloss_sticky_q <= inloss_sticky_d;
        end
    end

    // ============================================================
    // masks and plain configuration
    logic [7:0] alarm_mask_q;
    logic [7:0] alarm_mask_d;
    logic [7:0] inloss_mask_q;
    logic [7:0] inloss_mask_d;
    logic [7:0] ref_select_q;
    logic [7:0] ref_select_d;
    logic [7:0] wire_mode_q;
    logic [7:0] wire_mode_d;
    logic       low_power_q;
    logic       low_power_d;
    logic       hard_reset_q;
    logic       hard_reset_d;

    always_comb begin
        alarm_mask_d  = alarm_mask_q;
        inloss_mask_d = inloss_mask_q;
        ref_select_d  = ref_select_q;
        wire_mode_d   = wire_mode_q;
        low_power_d   = low_power_q;
        hard_reset_d  = hard_reset_q;
        if (wr_alarm_mask) begin
            alarm_mask_d = wr.data & ALARM_VALID;
        end
        if (wr_inloss_mask) begin
            inloss_mask_d = wr.data & INLOSS_VALID;
        end
        if (wr_ref_select) begin
            ref_select_d = wr.data & 8'h07;
        end
        if (wr_wire_mode) begin
            wire_mode_d = wr.data & 8'h08;
        end
        // hard reset stays until software writes it back to 0
        if (wr_power) begin
            low_power_d  = wr.data[BIT_LOW_POWER];
            hard_reset_d = wr.data[BIT_HARD_RESET];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_mask_q  <= RST_ALARM_MASK;
            inloss_mask_q <= RST_INLOSS_MASK;
            ref_select_q  <= RST_REF_SELECT;
            wire_mode_q   <= RST_WIRE_MODE;
            low_power_q   <= 1'b0;
            hard_reset_q  <= 1'b0;
        end else if (ce) begin
            alarm_mask_q  <= alarm_mask_d;
            inloss_mask_q <= inloss_mask_d;
            ref_select_q  <= ref_select_d;
            wire_mode_q   <= wire_mode_d;
            low_power_q   <= low_power_d;
            hard_reset_q  <= hard_reset_d;
        end
    end

    // ============================================================
    // selection pin synchroniser
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;
    logic [1:0] pin_sel_q;
    logic [1:0] pin_sel_d;

    // a new pin value counts only once stages two and three agree
    always_comb begin
        pin_sel_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_sel_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q  <= RST_PIN_SELECT;
            pin_s2_q  <= RST_PIN_SELECT;
            pin_s3_q  <= RST_PIN_SELECT;
            pin_sel_q <= RST_PIN_SELECT;
        end else if (ce) begin
            pin_s1_q  <= ref_select_pins;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            pin_sel_q <= pin_sel_d;
        end
    end

    // ============================================================
    // control outputs and interrupt
    core_ctrl_t ctrl_d;
    logic       irq_d;

    always_comb begin
        ctrl_d                  = '0;
        ctrl_d.soft_reset_pulse = wr_soft_reset && wr.data[BIT_SOFT_RESET];
        ctrl_d.freq_step_up     = wr_freq_step && wr.data[BIT_STEP_UP];
        ctrl_d.freq_step_down   = wr_freq_step && wr.data[BIT_STEP_DOWN];
        // soft reset realigns the outputs too, so skew is restored
        ctrl_d.align_pulse      = (wr_power && wr.data[BIT_ALIGN]) || ctrl_d.soft_reset_pulse;
        ctrl_d.low_power_request = low_power_d;
        ctrl_d.hard_reset        = hard_reset_d;
        ctrl_d.shared_data_line_mode = wire_mode_d[BIT_SHARED_LINE];
        ctrl_d.reference_select = ref_select_d[BIT_SEL_SOURCE]
                                  ? ref_select_d[SEL_FIELD_LSB +: 2] : pin_sel_d;
        irq_d = |(alarm_sticky_q & ~alarm_mask_q) || |(inloss_sticky_q & ~inloss_mask_q);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= '0;
            irq_q  <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            irq_q  <= irq_d;
        end
    end

    // ============================================================
    // read port; self-clearing bits read back as zero
    logic [7:0] rd_data_d;

    always_comb begin
        case (rd_addr)
            ADDR_LIVE_ALARM:    rd_data_d = alarm_live_vec;
            ADDR_LIVE_INLOSS:   rd_data_d = inloss_live_vec;
            ADDR_ALARM_STICKY:  rd_data_d = alarm_sticky_q;
            ADDR_INLOSS_STICKY: rd_data_d = inloss_sticky_q;
            ADDR_ALARM_MASK:    rd_data_d = alarm_mask_q;
            ADDR_INLOSS_MASK:   rd_data_d = inloss_mask_q;
            ADDR_POWER_CTRL:    rd_data_d = {6'h00, hard_reset_q, low_power_q};
            ADDR_REF_SELECT:    rd_data_d = ref_select_q;
            ADDR_WIRE_MODE:     rd_data_d = wire_mode_q;
            default:            rd_data_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            rd_data_q  <= rd_en ? rd_data_d : 8'h00;
            rd_valid_q <= rd_en;
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_alarm_set;
        ce |=> ((alarm_sticky_q & ($past(alarm_live_vec) & ALARM_VALID)) == ($past(alarm_live_vec) & ALARM_VALID));
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("live alarm did not set sticky flag");

    property p_alarm_clear;
        ce && wr_alarm_sticky |=> alarm_sticky_q ==
            ((($past(alarm_sticky_q) & $past(wr.data)) | $past(alarm_live_vec)) & ALARM_VALID);
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarm write-zero clear wrong");

    property p_inloss_clear;
        ce && wr_inloss_sticky |=> inloss_sticky_q ==
            ((($past(inloss_sticky_q) & $past(wr.data)) | $past(inloss_live_vec)) & INLOSS_VALID);
    endproperty
    a_inloss_clear: assert property (p_inloss_clear) else $error("input loss clear wrong");

    property p_alarm_irq;
        ce && |(alarm_sticky_q & ~alarm_mask_q) |=> irq_q;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("unmasked alarm gave no interrupt");

    property p_irq_quiet;
        ce && !(|(alarm_sticky_q & ~alarm_mask_q)) && !(|(inloss_sticky_q & ~inloss_mask_q)) |=> !irq_q;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without unmasked flag");

    property p_soft_reset;
        ce && wr_soft_reset && wr.data[BIT_SOFT_RESET] |=> ctrl_q.soft_reset_pulse && ctrl_q.align_pulse
            ##1 (!ctrl_q.soft_reset_pulse || !$past(ce) || $past(wr_soft_reset && wr.data[BIT_SOFT_RESET]));
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset pulse wrong");

    property p_step;
        ce && wr_freq_step |=> (ctrl_q.freq_step_up == $past(wr.data[BIT_STEP_UP]))
            && (ctrl_q.freq_step_down == $past(wr.data[BIT_STEP_DOWN]));
    endproperty
    a_step: assert property (p_step) else $error("frequency step pulse wrong");

    property p_hard_hold;
        ce && ctrl_q.hard_reset && !wr_power |=> ctrl_q.hard_reset;
    endproperty
    a_hard_hold: assert property (p_hard_hold) else $error("hard reset cleared itself");

    property p_reg_select;
        ce && wr_ref_select && wr.data[BIT_SEL_SOURCE] |=> ctrl_q.reference_select == $past(wr.data[2:1]);
    endproperty
    a_reg_select: assert property (p_reg_select) else $error("register selection not applied");

    property p_pin_select;
        ce && !ref_select_q[BIT_SEL_SOURCE] && !wr_ref_select |=> ctrl_q.reference_select == pin_sel_q;
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("pin selection not applied");

    property p_live_read;
        ce && rd_en && rd_addr == ADDR_LIVE_ALARM |=> rd_valid_q && rd_data_q == $past(alarm_live_vec);
    endproperty
    a_live_read: assert property (p_live_read) else $error("live alarm read wrong");

    c_clear_race: cover property (ce && wr_alarm_sticky && |(alarm_live_vec & ~wr.data & ALARM_VALID));
    c_irq:        cover property (ce && !irq_q ##1 irq_q);
    c_align:      cover property (ce && wr_power && wr.data[BIT_ALIGN]);
    c_pin_change: cover property (ce && pin_sel_d != pin_sel_q);

endmodule // status_flag_and_control_regs

// [testbench/tb_status_flag_and_control_regs.sv]
// testbench: self-checking scenarios for the status flag and control register bank
module tb_status_flag_and_control_regs
    import clkgen_csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // stimulus and observed signals
    logic        clk;
    logic        arst_n;
    logic        ce;
    reg_wr_t     wr;
    logic        rd_en;
    reg_addr_t   rd_addr;
    alarm_live_t alarm_live;
    logic [3:0]  input_loss_live;
    logic [1:0]  ref_select_pins;
    logic [7:0]  rd_data_q;
    logic        rd_valid_q;
    logic        irq_q;
    core_ctrl_t  ctrl_q;
    int          mismatches;
    int          n_tests;

    status_flag_and_control_regs status_flag_and_control_regs_inst (
        .clk             (clk),
        .arst_n          (arst_n),
        .ce              (ce),
        .wr              (wr),
        .rd_en           (rd_en),
        .rd_addr         (rd_addr),
        .alarm_live      (alarm_live),
        .input_loss_live (input_loss_live),
        .ref_select_pins (ref_select_pins),
        .rd_data_q       (rd_data_q),
        .rd_valid_q      (rd_valid_q),
        .irq_q           (irq_q),
        .ctrl_q          (ctrl_q)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ============================================================
    // shared tasks
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // idle edge first, so back-to-back calls never lower and raise a strobe in one time step
    task automatic reg_write(input reg_addr_t a, input logic [7:0] d);
        tick();
        wr = '{en: 1'b1, addr: a, data: d};
        tick();
        wr.en = 1'b0;
    endtask

    // answer lands one edge after the strobe and stands one cycle
    task automatic reg_read(input reg_addr_t a, input logic [7:0] exp);
        tick();
        rd_en   = 1'b1;
        rd_addr = a;
        tick();
        rd_en = 1'b0;
        check("rd_valid", {7'h0, rd_valid_q}, 8'h01);
        check($sformatf("reg %h", a), rd_data_q, exp);
    endtask

    function automatic logic [7:0] alarm_pos(input alarm_live_t a);
        return {2'h0, a.bus_timeout, 1'b0, a.lock_loss_status, a.reference_signal_loss,
                a.crystal_signal_loss, a.calibrating_status};
    endfunction

    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset_and_refusals();
        reg_addr_t list [9] = '{16'h000c, 16'h000d, 16'h0011, 16'h0012, 16'h0017, 16'h0018,
                                16'h001e, 16'h0021, 16'h002b};
        foreach (list[i]) reg_read(list[i], 8'h00);
        reg_read(16'h0013, 8'h00);
        reg_write(16'h000c, 8'hff);
        reg_read(16'h000c, 8'h00);
        check("irq idle", {7'h0, irq_q}, 8'h00);
    endtask

    task automatic t_sticky_alarms();
        logic [7:0] m;
        for (int i = 0; i < 5; i++) begin
            alarm_live = alarm_live_t'(5'h01 << i);
            m = alarm_pos(alarm_live);
            reg_read(16'h000c, m);
            alarm_live = '0;
            reg_read(16'h0011, m);
            check("irq set", {7'h0, irq_q}, 8'h01);
            reg_write(16'h0011, ~m);
            reg_read(16'h0011, 8'h00);
        end
        alarm_live.lock_loss_status = 1'b1;
        tick();
        reg_write(16'h0011, 8'h00);
        reg_read(16'h0011, 8'h08);
        alarm_live = '0;
        reg_write(16'h0011, 8'h00);
        reg_read(16'h0011, 8'h00);
        check("irq clear", {7'h0, irq_q}, 8'h00);
    endtask

    task automatic t_input_loss();
        input_loss_live = 4'h5;
        reg_read(16'h000d, 8'h05);
        input_loss_live = 4'h0;
        reg_read(16'h000d, 8'h00);
        reg_read(16'h0012, 8'h05);
        reg_write(16'h0012, 8'h0e);
        reg_read(16'h0012, 8'h04);
        reg_write(16'h0012, 8'h00);
        reg_read(16'h0012, 8'h00);
    endtask

    task automatic t_masks();
        reg_write(16'h0017, 8'h2f);
        reg_write(16'h0018, 8'h0f);
        reg_read(16'h0017, 8'h2f);
        reg_read(16'h0018, 8'h0f);
        alarm_live      = '1;
        input_loss_live = 4'hf;
        tick();
        alarm_live      = '0;
        input_loss_live = 4'h0;
        tick();
        tick();
        check("irq all masked", {7'h0, irq_q}, 8'h00);
        reg_write(16'h0018, 8'h07);
        tick();
        check("irq feedback", {7'h0, irq_q}, 8'h01);
        reg_write(16'h0018, 8'h0f);
        tick();
        check("irq remasked", {7'h0, irq_q}, 8'h00);
        reg_write(16'h0017, 8'h0f);
        tick();
        check("irq timeout", {7'h0, irq_q}, 8'h01);
        reg_write(16'h0011, 8'h00);
        reg_write(16'h0012, 8'h00);
        reg_write(16'h0017, 8'h00);
        reg_write(16'h0018, 8'h00);
        tick();
        check("irq cleared", {7'h0, irq_q}, 8'h00);
    endtask

    // pulse vector is {soft reset, step up, step down, align}
    task automatic t_pulses();
        reg_addr_t  a [8] = '{16'h001c, 16'h001c, 16'h001d, 16'h001d, 16'h001d, 16'h001d,
                              16'h001e, 16'h001e};
        logic [7:0] d [8] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h04};
        logic [3:0] e [8] = '{4'h0, 4'h9, 4'h0, 4'h4, 4'h2, 4'h6, 4'h0, 4'h1};
        for (int i = 0; i < 8; i++) begin
            reg_write(a[i], d[i]);
            check($sformatf("pulse %0d", i), {4'h0, ctrl_q[8:5]}, {4'h0, e[i]});
            tick();
            check($sformatf("pulse end %0d", i), {4'h0, ctrl_q[8:5]}, 8'h00);
        end
        reg_read(16'h001c, 8'h00);
        reg_read(16'h001d, 8'h00);
    endtask

    task automatic t_power_and_wire();
        reg_write(16'h001e, 8'h03);
        repeat (5) tick();
        check("power levels", {6'h0, ctrl_q.low_power_request, ctrl_q.hard_reset}, 8'h03);
        reg_read(16'h001e, 8'h03);
        reg_write(16'h001e, 8'h00);
        check("power off", {6'h0, ctrl_q.low_power_request, ctrl_q.hard_reset}, 8'h00);
        reg_write(16'h002b, 8'h08);
        check("three wire", {7'h0, ctrl_q.shared_data_line_mode}, 8'h01);
        reg_read(16'h002b, 8'h08);
        reg_write(16'h002b, 8'h00);
        check("four wire", {7'h0, ctrl_q.shared_data_line_mode}, 8'h00);
    endtask

    task automatic t_ref_select();
        ref_select_pins = 2'h2;
        repeat (6) tick();
        check("pin select", {6'h0, ctrl_q.reference_select}, 8'h02);
        for (int s = 0; s < 4; s++) begin
            reg_write(16'h0021, 8'((s << 1) | 1));
            tick();
            check("reg select", {6'h0, ctrl_q.reference_select}, 8'(s));
            reg_read(16'h0021, 8'((s << 1) | 1));
        end
        reg_write(16'h0021, 8'h06);
        tick();
        check("pins again", {6'h0, ctrl_q.reference_select}, 8'h02);
    endtask

    // a write offered while the clock enable is low must leave no trace
    task automatic t_clock_enable();
        ce = 1'b0;
        reg_write(16'h002b, 8'h08);
        check("frozen wire mode", {7'h0, ctrl_q.shared_data_line_mode}, 8'h00);
        ce = 1'b1;
        reg_read(16'h002b, 8'h00);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        mismatches      = 0;
        n_tests         = 0;
        arst_n          = 1'b0;
        ce              = 1'b1;
        wr              = '0;
        rd_en           = 1'b0;
        rd_addr         = '0;
        alarm_live      = '0;
        input_loss_live = 4'h0;
        ref_select_pins = 2'h0;
        repeat (10) tick();
        arst_n = 1'b1;
        t_reset_and_refusals();
        t_sticky_alarms();
        t_input_loss();
        t_masks();
        t_pulses();
        t_power_and_wire();
        t_ref_select();
        t_clock_enable();
        finish_test();
    end

    // whole run is a few hundred cycles; allow ample margin
    initial begin
        #200us;
        mismatches++;
        finish_test();
    end

endmodule // tb_status_flag_and_control_regs
